// *** voc_defs.svh ***
// offsets, field positions, reset values for the oscillator output config
`ifndef VOC_DEFS_SVH
`define VOC_DEFS_SVH

// ----------------------------------------------------------------------
// indirect write word layout
// ----------------------------------------------------------------------
`define VOC_IND_W 17
`define VOC_ID_LSB 0
`define VOC_ID_MSB 2
`define VOC_ADDR_LSB 3
`define VOC_ADDR_MSB 6
`define VOC_PAY_LSB 7
`define VOC_PAY_MSB 15
`define VOC_SUBSYS_ID 3'h0

// ----------------------------------------------------------------------
// subsystem register offsets
// ----------------------------------------------------------------------
`define VOC_OFS_OUTPUT_DIVIDER_CTRL 4'h2
`define VOC_OFS_OUTPUT_CONFIG_CTRL 4'h3
`define VOC_OFS_CALIBRATION_BIAS_CTRL 4'h4

// ----------------------------------------------------------------------
// reset values and divider limits
// ----------------------------------------------------------------------
`define VOC_RST_DIV 9'h001
`define VOC_RST_CFG 9'h091
`define VOC_RST_CAL 9'h0C9
`define VOC_DIV_MAX 6'h3E
`define VOC_DIV_MUTE 6'h00

`endif

// *** voc_pkg.sv ***
// types shared by the oscillator output configuration block
package voc_pkg;

	// ------------------------------------------------------------------
	// mute modes and priority codes
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		VOC_MM_DIV0,
		VOC_MM_CAL,
		VOC_MM_CAL_LOCK,
		VOC_MM_ALWAYS
	} voc_mute_mode_t;

	typedef enum logic [1:0] {
		VOC_PRI_BAD0,
		VOC_PRI_POWER,
		VOC_PRI_BAD2,
		VOC_PRI_PERF
	} voc_prio_t;

	// ------------------------------------------------------------------
	// register layouts
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [2:0] payload_hi;
		logic [5:0] ratio;
	} voc_div_t;

	typedef struct packed {
		voc_mute_mode_t mute_mode;
		logic rsv6;
		logic inc_res;
		logic int_term;
		logic neg_en;
		logic pos_en;
		voc_prio_t prio;
	} voc_cfg_t;

	typedef struct packed {
		logic [8:0] payload;
		logic [3:0] addr;
		logic [2:0] id;
	} voc_wr_t;

endpackage

// *** voc_regs.sv ***
// write-only output divider, config and cal/bias registers with mute logic
`timescale 1ns/1ps
`include "voc_defs.svh"

module voc_regs
	import voc_pkg::*;
(
	input wire logic CLK,
	input wire logic SRST,
	input wire logic IND_WE,
	input wire logic [`VOC_IND_W-1:0] IND_DATA,
	input wire logic CAL_BUSY,
	input wire logic GEN_OUT_SIG,
	output logic [5:0] DIV_RATIO,
	output logic MUTE,
	output logic [1:0] PRIORITY,
	output logic POS_OUT_EN,
	output logic NEG_OUT_EN,
	output logic INT_TERM_EN,
	output logic INC_OUT_RES,
	output logic [8:0] CAL_BIAS
);

	// ------------------------------------------------------------------
	// divide ratio mapping
	// ------------------------------------------------------------------
	function automatic logic [5:0] eff_ratio(input logic [5:0] raw);
		logic [5:0] r;
		r = raw;
		if (raw > `VOC_DIV_MAX) begin
			r = `VOC_DIV_MAX;
		end else if (raw > 6'h01) begin
			r = {raw[5:1], 1'b0};
		end
		return r;
	endfunction

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	voc_wr_t wr;
	voc_div_t div_r, div_nxt;
	voc_cfg_t cfg_r, cfg_nxt;
	logic [8:0] cal_r, cal_nxt;
	logic sel;
	logic [5:0] ratio_nxt;
	logic mute_nxt;

	// split the indirect word into id, address and payload
	always_comb begin
		wr.id = IND_DATA[`VOC_ID_MSB:`VOC_ID_LSB];
		wr.addr = IND_DATA[`VOC_ADDR_MSB:`VOC_ADDR_LSB];
		wr.payload = IND_DATA[`VOC_PAY_MSB:`VOC_PAY_LSB];
		sel = IND_WE && (wr.id == `VOC_SUBSYS_ID);
	end

	// register write decode; no read path exists
	always_comb begin
		div_nxt = div_r;
		cfg_nxt = cfg_r;
		cal_nxt = cal_r;
		if (sel) begin
			case (wr.addr)
				`VOC_OFS_OUTPUT_DIVIDER_CTRL: begin
					div_nxt = voc_div_t'(wr.payload);
				end
				`VOC_OFS_OUTPUT_CONFIG_CTRL: begin
					cfg_nxt = voc_cfg_t'(wr.payload);
				end
				`VOC_OFS_CALIBRATION_BIAS_CTRL: begin
					cal_nxt = wr.payload;
				end
				default: begin
					cal_nxt = cal_r;
				end
			endcase
		end
	end

	// register storage with documented reset values
	always_ff @(posedge CLK) begin
		if (SRST) begin
			div_r <= voc_div_t'(`VOC_RST_DIV);
			cfg_r <= voc_cfg_t'(`VOC_RST_CFG);
			cal_r <= `VOC_RST_CAL;
		end else begin
			div_r <= div_nxt;
			cfg_r <= cfg_nxt;
			cal_r <= cal_nxt;
		end
	end

	// ------------------------------------------------------------------
	// output controls
	// ------------------------------------------------------------------
	// effective ratio and mute decision from the next register contents
	always_comb begin
		ratio_nxt = eff_ratio(div_nxt.ratio);
		mute_nxt = (div_nxt.ratio == `VOC_DIV_MUTE);
		case (cfg_nxt.mute_mode)
			VOC_MM_DIV0: begin
				mute_nxt = mute_nxt;
			end
			VOC_MM_CAL: begin
				mute_nxt = mute_nxt || CAL_BUSY;
			end
			VOC_MM_CAL_LOCK: begin
				mute_nxt = mute_nxt || CAL_BUSY || !GEN_OUT_SIG;
			end
			VOC_MM_ALWAYS: begin
				mute_nxt = 1'b1;
			end
			default: begin
				mute_nxt = 1'b1;
			end
		endcase
	end

	// output flops
	always_ff @(posedge CLK) begin
		if (SRST) begin
			DIV_RATIO <= 6'h01;
			MUTE <= 1'b0;
			PRIORITY <= 2'h1;
			POS_OUT_EN <= 1'b0;
			NEG_OUT_EN <= 1'b0;
			INT_TERM_EN <= 1'b1;
			INC_OUT_RES <= 1'b0;
			CAL_BIAS <= `VOC_RST_CAL;
		end else begin
			DIV_RATIO <= ratio_nxt;
			MUTE <= mute_nxt;
			PRIORITY <= cfg_nxt.prio;
			POS_OUT_EN <= cfg_nxt.pos_en;
			NEG_OUT_EN <= cfg_nxt.neg_en;
			INT_TERM_EN <= cfg_nxt.int_term;
			INC_OUT_RES <= cfg_nxt.inc_res;
			CAL_BIAS <= cal_nxt;
		end
	end

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (SRST);

	// even nonzero write shows up on the next cycle
	AST_DIV_EVEN: assert property (
		(sel && wr.addr == `VOC_OFS_OUTPUT_DIVIDER_CTRL
			&& wr.payload[0] == 1'b0 && wr.payload[5:0] != 6'h00)
		|=> DIV_RATIO == $past(wr.payload[5:0]))
		else $error("even divide ratio not applied");

	AST_DIV_ODD: assert property (
		(div_r.ratio[0] && div_r.ratio > 6'h01 && div_r.ratio < 6'h3E)
		|-> DIV_RATIO == div_r.ratio - 6'h01)
		else $error("odd divide ratio not rounded down");

	AST_DIV_HIGH: assert property (
		(div_r.ratio > 6'h3E) |-> DIV_RATIO == 6'h3E)
		else $error("oversize divide ratio not clamped");

	AST_DIV_ZERO_MUTE: assert property (
		(div_r.ratio == 6'h00) |-> MUTE)
		else $error("zero divide did not mute");

	AST_PRIO_WRITE: assert property (
		(sel && wr.addr == `VOC_OFS_OUTPUT_CONFIG_CTRL)
		|=> PRIORITY == $past(wr.payload[1:0])
			&& POS_OUT_EN == $past(wr.payload[2])
			&& NEG_OUT_EN == $past(wr.payload[3]))
		else $error("config write not reflected");

	AST_RESET_VALUES: assert property (
		$past(SRST) |-> PRIORITY == 2'h1 && !POS_OUT_EN
			&& !NEG_OUT_EN && INT_TERM_EN && !INC_OUT_RES)
		else $error("config reset values wrong");

	AST_MUTE_CAL: assert property (
		(cfg_r.mute_mode == VOC_MM_CAL && !$past(SRST)) |->
			MUTE == ($past(CAL_BUSY) || div_r.ratio == 6'h00))
		else $error("calibration mute wrong");

	AST_MUTE_LOCK: assert property (
		(cfg_r.mute_mode == VOC_MM_CAL_LOCK && !$past(GEN_OUT_SIG))
		|-> MUTE)
		else $error("lock loss did not mute");

	AST_MUTE_ALWAYS: assert property (
		(cfg_r.mute_mode == VOC_MM_ALWAYS) |-> MUTE)
		else $error("permanent mute not held");

	AST_FOREIGN_ID: assert property (
		(IND_WE && wr.id != `VOC_SUBSYS_ID) |=> $stable(cfg_r)
			&& $stable(div_r) && $stable(cal_r))
		else $error("write to another subsystem changed state");

	COV_DIV_ODD: cover property (
		sel && wr.addr == `VOC_OFS_OUTPUT_DIVIDER_CTRL && wr.payload[0]);
	COV_CAL_MUTE: cover property (
		cfg_r.mute_mode == VOC_MM_CAL ##1 CAL_BUSY ##1 MUTE);
	COV_LOCK_MUTE: cover property (
		cfg_r.mute_mode == VOC_MM_CAL_LOCK && !GEN_OUT_SIG ##1 MUTE);
	COV_PERF: cover property (PRIORITY == 2'h3);

endmodule

// *** voc_host.sv ***
// host model writing subsystem registers through the indirect word
`timescale 1ns/1ps
module voc_host
	import voc_pkg::*;
(
	input wire logic CLK,
	output logic IND_WE,
	output logic [16:0] IND_DATA
);
	// idle bus at time zero
	initial begin
		IND_WE = 1'b0;
		IND_DATA = 17'h00000;
	end

	// -----------------------------------------------------------------
	// one-cycle write strobe
	// -----------------------------------------------------------------
	// packs id, address and payload into place
	// data inverted once the strobe drops, never left showing
	task automatic wr(input logic [2:0] id, input logic [3:0] adr,
		input logic [8:0] pay);
		voc_wr_t w;
		w.id = id;
		w.addr = adr;
		w.payload = pay;
		@(posedge CLK);
		IND_WE <= 1'b1;
		IND_DATA <= {1'b0, w};
		@(posedge CLK);
		IND_WE <= 1'b0;
		IND_DATA <= ~{1'b0, w};
	endtask
endmodule

// *** tb_top.sv ***
// self-checking bench for the oscillator output config registers
`timescale 1ns/1ps
module tb_top;
	import voc_pkg::*;
	logic CLK = 1'b0;
	logic SRST = 1'b1;
	logic CAL_BUSY = 1'b0;
	logic GEN_OUT_SIG = 1'b1;
	logic IND_WE;
	logic [16:0] IND_DATA;
	logic [5:0] DIV_RATIO;
	logic MUTE, POS_OUT_EN, NEG_OUT_EN, INT_TERM_EN, INC_OUT_RES;
	logic [1:0] PRIORITY;
	logic [8:0] CAL_BIAS;
	int n_errors = 0;
	int checked = 0;

	// 50 MHz clock
	always #10 CLK = ~CLK;

	voc_regs dut (.CLK(CLK), .SRST(SRST), .IND_WE(IND_WE),
		.IND_DATA(IND_DATA), .CAL_BUSY(CAL_BUSY),
		.GEN_OUT_SIG(GEN_OUT_SIG), .DIV_RATIO(DIV_RATIO), .MUTE(MUTE),
		.PRIORITY(PRIORITY), .POS_OUT_EN(POS_OUT_EN),
		.NEG_OUT_EN(NEG_OUT_EN), .INT_TERM_EN(INT_TERM_EN),
		.INC_OUT_RES(INC_OUT_RES), .CAL_BIAS(CAL_BIAS));
	voc_host host (.CLK(CLK), .IND_WE(IND_WE), .IND_DATA(IND_DATA));

	// -----------------------------------------------------------------
	// helpers
	// -----------------------------------------------------------------
	task automatic chk(input string nm, input logic [8:0] got,
		input logic [8:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s exp %h got %h", nm, exp, got);
		end
	endtask

	task automatic settle;
		repeat (2) @(posedge CLK);
		#1;
	endtask

	task automatic do_reset;
		@(posedge CLK);
		SRST <= 1'b1;
		repeat (16) @(posedge CLK);
		SRST <= 1'b0;
		settle;
	endtask

	task automatic end_sim;
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// -----------------------------------------------------------------
	// scenarios
	// -----------------------------------------------------------------
	task automatic t_rst_vals;
		chk("ratio", 9'(DIV_RATIO), 9'h001);
		chk("mute", 9'(MUTE), 9'h000);
		chk("prio", 9'(PRIORITY), 9'h001);
		chk("pos", 9'(POS_OUT_EN), 9'h000);
		chk("neg", 9'(NEG_OUT_EN), 9'h000);
		chk("term", 9'(INT_TERM_EN), 9'h001);
		chk("res", 9'(INC_OUT_RES), 9'h000);
		chk("cal", CAL_BIAS, 9'h0C9);
	endtask

	task automatic t_ratio;
		logic [5:0] e;
		for (int i = 0; i < 64; i++) begin
			e = (i > 62) ? 6'h3E : (i < 2) ? 6'(i) : 6'(i) & 6'h3E;
			host.wr(3'h0, 4'h2, {3'h0, 6'(i)});
			settle;
			chk("ratio", 9'(DIV_RATIO), 9'(e));
			chk("mute0", 9'(MUTE), 9'(i == 0));
		end
	endtask

	task automatic t_cfg;
		logic [8:0] v[2] = '{9'h0A7, 9'h099};
		foreach (v[k]) begin
			host.wr(3'h0, 4'h3, v[k]);
			settle;
			chk("prio", 9'(PRIORITY), 9'(v[k][1:0]));
			chk("pos", 9'(POS_OUT_EN), 9'(v[k][2]));
			chk("neg", 9'(NEG_OUT_EN), 9'(v[k][3]));
			chk("term", 9'(INT_TERM_EN), 9'(v[k][4]));
			chk("res", 9'(INC_OUT_RES), 9'(v[k][5]));
		end
	endtask

	task automatic t_mute;
		logic e;
		host.wr(3'h0, 4'h2, 9'h002);
		for (int m = 0; m < 4; m++) begin
			host.wr(3'h0, 4'h3, {2'(m), 7'h11});
			for (int s = 0; s < 4; s++) begin
				@(posedge CLK);
				CAL_BUSY <= s[0];
				GEN_OUT_SIG <= s[1];
				settle;
				e = (m == 3) || (m > 0 && s[0]) || (m == 2 && !s[1]);
				chk("mute", 9'(MUTE), 9'(e));
			end
		end
		@(posedge CLK);
		CAL_BUSY <= 1'b0;
		GEN_OUT_SIG <= 1'b1;
	endtask

	task automatic t_ignore;
		host.wr(3'h0, 4'h2, 9'h004);
		host.wr(3'h1, 4'h2, 9'h00A);
		host.wr(3'h0, 4'h5, 9'h00A);
		host.wr(3'h1, 4'h4, 9'h000);
		settle;
		chk("ratio", 9'(DIV_RATIO), 9'h004);
		chk("cal", CAL_BIAS, 9'h0C9);
	endtask

	task automatic t_cal_reset;
		host.wr(3'h0, 4'h4, 9'h0C9);
		host.wr(3'h0, 4'h3, 9'h0A7);
		settle;
		chk("cal", CAL_BIAS, 9'h0C9);
		do_reset;
		t_rst_vals;
	endtask

	// main sequence
	initial begin
		do_reset;
		t_rst_vals;
		t_ratio;
		t_cfg;
		t_mute;
		t_ignore;
		t_cal_reset;
		end_sim;
	end
endmodule
